// File: core/lich_divider.sv
// Clock divider that toggles its output every half period
`timescale 1ns/1ps
module lich_divider #(
  parameter int DIV = 512
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  output logic div_out
);
  localparam int HALF = DIV / 2;
  logic [15:0] cnt;
  wire last = (cnt == 16'(HALF - 1));
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt <= 16'h0000;
      div_out <= 1'b0;
    end else if (tick) begin
      cnt <= last ? 16'h0000 : cnt + 16'h0001;
      if (last) begin
        div_out <= ~div_out;
      end
    end
  end
endmodule : lich_divider

// File: core/lich_pkg.sv
// Package for the loop instrument command handler: offsets, codes, constants
package lich_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COEF_IDX = 8'h08;
  localparam logic [7:0] OFF_COEF_DATA = 8'h0C;
  localparam logic [7:0] OFF_INTEG = 8'h10;
  localparam logic [7:0] OFF_PPER = 8'h14;
  localparam logic [7:0] OFF_INTEG_TIME = 8'h18;
  localparam logic [7:0] OFF_RES_DEN = 8'h1C;
  localparam logic [7:0] OFF_RELAY = 8'h20;
  localparam logic [7:0] OFF_MY_ADDR = 8'h24;
  localparam logic [7:0] OFF_SCALED_P = 8'h28;
  localparam logic [7:0] OFF_PCALC = 8'h2C;
  // CMD register field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 5;
  localparam int CMD_DEST_LSB = 8;
  localparam int CMD_DEST_W = 7;
  localparam int CMD_WRITE_BIT = 16;
  // Status bit positions
  localparam int ST_UNLOCK = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_DIAG_CT = 2;
  localparam int ST_DIAG_CX = 3;
  localparam int ST_HOLD = 4;
  localparam int ST_RELAY_PEND = 5;
  localparam int ST_ACCEPTED = 6;
  // Addressing
  localparam logic [6:0] GLOBAL_ADDR = 7'h63;
  localparam logic [6:0] MY_ADDR_RST = 7'h01;
  // Divisors
  localparam int CT_DIV = 512;
  localparam int CX_DIV = 480;
  // Integration
  localparam logic [15:0] INTEG_FACTORY = 16'h00EE;
  localparam int INTEG_TIME_DIV = 10000;
  localparam int RES_MULT = 150;
  localparam logic [15:0] PPER_RST = 16'h001C;
  // Coefficients
  localparam int NUM_COEF = 17;
  localparam logic [4:0] COEF_SN = 5'h00;
  localparam logic [4:0] COEF_ADDER = 5'h01;
  localparam logic [4:0] COEF_MULT = 5'h02;
  localparam logic [4:0] COEF_TBC = 5'h03;
  localparam logic [23:0] SN_MAX = 24'h0F423F;
  // Timebase correction reset 1.0 in Q8.24; reference rate in MHz
  localparam logic [31:0] ONE_Q24 = 32'h01000000;
  localparam int TBC_REF_MHZ = 10;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_COUNTER_TIMEBASE_CHECK = 5'h01,
    OP_CRYSTAL_CLOCK_CHECK = 5'h02,
    OP_WRITE_UNLOCK = 5'h03,
    OP_COEF_ACCESS = 5'h04,
    OP_LINE_SPEED_SET = 5'h05,
    OP_GLOBAL_ONLY_B = 5'h06,
    OP_LOOP_AUTO_NUMBERING = 5'h07,
    OP_GLOBAL_ONLY_T = 5'h08,
    OP_SAMPLE_HOLD_PRESSURE_A = 5'h09,
    OP_SAMPLE_HOLD_PRESSURE_B = 5'h0A,
    OP_SAMPLE_HOLD_PERIOD_A = 5'h0B,
    OP_SAMPLE_HOLD_PERIOD_B = 5'h0C,
    OP_VERSION_QUERY = 5'h0D,
    OP_DATA_DUMP = 5'h0E,
    OP_SAMPLE_OTHER = 5'h0F,
    OP_INTEG_SET = 5'h10
  } lich_op_type;
  typedef enum logic [1:0] {
    DG_OFF = 2'b00,
    DG_CT = 2'b01,
    DG_CX = 2'b10
  } lich_diag_type;
endpackage : lich_pkg

// File: core/lich_top.sv
// Command handler of a loop-addressed instrument, with APB register access
// What this block does
// - Counter timebase check puts timebase divided by 512 on display clock.
// - Crystal check puts processor clock divided by 480 on display clock.
// - Either divided output runs only until the next command for this unit arrives.
// - Timebase output is resampled in clk domain so edges may jitter.
// - Coefficient writes are refused unless write unlock came just before.
// - Coefficient reads and writes are taken only when individually addressed.
// - Reported pressure is multiplier times the sum of calculated pressure and adder.
// - Timebase correction is ten megahertz over oscillator rate, read/write.
// - Each calibration coefficient is stored, read back, replaced on unlocked write.
// - Destination address 99 is global, acted on by every instrument.
// - Line speed, auto-numbering and two loop commands act only when global.
// - Global sample-and-hold captures measurements at the same moment.
// - Sampling, dump, version and unlock accept individual or global address.
// - A global command is relayed onward in the cycle it is executed, or one cycle later for version and dump.
// - Except version and dump, the echo goes out in the same cycle as responses.
// - Integration setting is kept, with factory value 238.
// - Integration time is setting times period over 10000; resolution uses 150.
// - Messages for this unit are taken; others are passed onward.
`timescale 1ns/1ps
module lich_top #(
  parameter int CT_DIV = lich_pkg::CT_DIV,
  parameter int CX_DIV = lich_pkg::CX_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_timebase,
  input wire logic [31:0] live_pressure,
  input wire logic [31:0] live_period,
  output logic display_clock,
  output logic relay_valid,
  output logic [31:0] relay_cmd,
  output logic reply_valid,
  output logic [31:0] reply_data,
  output logic [31:0] held_pressure,
  output logic [31:0] held_period,
  output logic [6:0] next_auto_addr,
  output logic line_speed_strobe,
  output logic [3:0] line_speed_code
);
  // Coefficient store: index 0 serial number, 1 adder, 2 multiplier, 3 timebase, rest curve
  logic [31:0] coef [lich_pkg::NUM_COEF];
  logic [6:0] my_addr;
  logic unlock;
  logic refused;
  logic accepted;
  logic hold;
  logic [1:0] diag;
  logic [4:0] coef_idx;
  logic [15:0] integ_setting;
  logic [15:0] pper;
  logic [31:0] pcalc;
  logic relay_pend;
  logic [31:0] pend_cmd;
  logic tb_s1;
  logic tb_s2;
  logic tb_s3;
  logic ct_out;
  logic cx_out;

  function automatic logic [23:0] bcd_of(input logic [31:0] v);
    logic [19:0] n;
    logic [23:0] r;
    n = (v > 32'(lich_pkg::SN_MAX)) ? 20'(lich_pkg::SN_MAX) : v[19:0];
    r = 24'h000000;
    for (int i = 0; i < 6; i++) begin
      r[i*4 +: 4] = 4'(n % 20'd10);
      n = n / 20'd10;
    end
    return r;
  endfunction : bcd_of

  // APB decode
  wire wr_en = psel && penable && pwrite && pready;
  wire rd_en = psel && penable && !pwrite && pready;
  wire cmd_wr = wr_en && (paddr == lich_pkg::OFF_CMD);
  wire [4:0] op = pwdata[lich_pkg::CMD_OP_LSB +: lich_pkg::CMD_OP_W];
  wire [6:0] dest = pwdata[lich_pkg::CMD_DEST_LSB +: lich_pkg::CMD_DEST_W];
  wire cmd_write = pwdata[lich_pkg::CMD_WRITE_BIT];
  wire is_global = (dest == lich_pkg::GLOBAL_ADDR);
  wire is_mine = (dest == my_addr);
  wire for_me = is_mine || is_global;
  wire global_only = (op == lich_pkg::OP_LINE_SPEED_SET) || (op == lich_pkg::OP_GLOBAL_ONLY_B)
    || (op == lich_pkg::OP_LOOP_AUTO_NUMBERING) || (op == lich_pkg::OP_GLOBAL_ONLY_T);
  wire either_addr = (op >= lich_pkg::OP_SAMPLE_HOLD_PRESSURE_A && op <= lich_pkg::OP_SAMPLE_OTHER)
    || (op == lich_pkg::OP_WRITE_UNLOCK);
  wire individual_only = (op == lich_pkg::OP_COEF_ACCESS) || (op == lich_pkg::OP_INTEG_SET)
    || (op == lich_pkg::OP_COUNTER_TIMEBASE_CHECK) || (op == lich_pkg::OP_CRYSTAL_CLOCK_CHECK);
  wire addr_ok = (global_only && is_global) || (either_addr && for_me)
    || (individual_only && is_mine);
  wire needs_unlock = cmd_write && ((op == lich_pkg::OP_COEF_ACCESS)
    || (op == lich_pkg::OP_INTEG_SET));
  wire take = cmd_wr && addr_ok && !(needs_unlock && !unlock);
  wire refuse = cmd_wr && for_me && !take;
  wire is_sample_hold = (op >= lich_pkg::OP_SAMPLE_HOLD_PRESSURE_A)
    && (op <= lich_pkg::OP_SAMPLE_HOLD_PERIOD_B);
  // Echo in the same cycle as reply except version and dump, whose echo trails the reply
  wire echo_first = !((op == lich_pkg::OP_VERSION_QUERY) || (op == lich_pkg::OP_DATA_DUMP));
  wire diag_op = (op == lich_pkg::OP_COUNTER_TIMEBASE_CHECK)
    || (op == lich_pkg::OP_CRYSTAL_CLOCK_CHECK);
  wire [31:0] coef_sel = coef[coef_idx];
  // Products for integration time and resolution denominator
  wire [31:0] integ_prod = integ_setting * pper;
  wire [31:0] integ_time_q = 32'(integ_prod * 32'd1000 / 32'(lich_pkg::INTEG_TIME_DIV));
  wire [31:0] res_den = 32'(integ_prod * 32'(lich_pkg::RES_MULT));
  // Pressure scaling in Q8.24 fixed point
  wire [63:0] scaled_full = $signed(coef[lich_pkg::COEF_MULT])
    * $signed(pcalc + coef[lich_pkg::COEF_ADDER]);
  wire [31:0] scaled_p = scaled_full[55:24];
  wire [31:0] status_word = {25'h0000000, accepted, relay_pend, hold,
    diag == lich_pkg::DG_CX, diag == lich_pkg::DG_CT, refused, unlock};
  wire [31:0] next_rd = (paddr == lich_pkg::OFF_STATUS) ? status_word
    : (paddr == lich_pkg::OFF_COEF_IDX) ? {27'h0000000, coef_idx}
    : (paddr == lich_pkg::OFF_COEF_DATA) ? coef_sel
    : (paddr == lich_pkg::OFF_INTEG) ? {16'h0000, integ_setting}
    : (paddr == lich_pkg::OFF_PPER) ? {16'h0000, pper}
    : (paddr == lich_pkg::OFF_INTEG_TIME) ? integ_time_q
    : (paddr == lich_pkg::OFF_RES_DEN) ? res_den
    : (paddr == lich_pkg::OFF_RELAY) ? relay_cmd
    : (paddr == lich_pkg::OFF_MY_ADDR) ? {25'h0000000, my_addr}
    : (paddr == lich_pkg::OFF_SCALED_P) ? scaled_p
    : (paddr == lich_pkg::OFF_PCALC) ? pcalc
    : 32'h00000000;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= lich_pkg::OFF_PCALC);
  wire [6:0] next_relay_dest = (op == lich_pkg::OP_LOOP_AUTO_NUMBERING) ? my_addr + 7'h01 : dest;

  // APB slave: one wait state, answer in second access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= next_rd;
      end
    end
  end

  // Command state
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock <= 1'b0;
      refused <= 1'b0;
      accepted <= 1'b0;
      diag <= lich_pkg::DG_OFF;
      hold <= 1'b0;
      coef_idx <= 5'h00;
      my_addr <= lich_pkg::MY_ADDR_RST;
      integ_setting <= lich_pkg::INTEG_FACTORY;
      pper <= lich_pkg::PPER_RST;
      pcalc <= 32'h00000000;
      line_speed_strobe <= 1'b0;
      line_speed_code <= 4'h0;
      next_auto_addr <= 7'h00;
      held_pressure <= 32'h00000000;
      held_period <= 32'h00000000;
    end else begin
      line_speed_strobe <= 1'b0;
      if (cmd_wr && for_me) begin
        accepted <= take;
        refused <= refuse;
        diag <= lich_pkg::DG_OFF;
        unlock <= take && (op == lich_pkg::OP_WRITE_UNLOCK);
      end
      if (take && op == lich_pkg::OP_COUNTER_TIMEBASE_CHECK) begin
        diag <= lich_pkg::DG_CT;
      end
      if (take && op == lich_pkg::OP_CRYSTAL_CLOCK_CHECK) begin
        diag <= lich_pkg::DG_CX;
      end
      if (take && is_sample_hold) begin
        hold <= 1'b1;
        held_pressure <= live_pressure;
        held_period <= live_period;
      end
      if (take && op == lich_pkg::OP_DATA_DUMP) begin
        hold <= 1'b0;
      end
      if (take && op == lich_pkg::OP_LINE_SPEED_SET) begin
        line_speed_strobe <= 1'b1;
        line_speed_code <= pwdata[27:24];
      end
      if (take && op == lich_pkg::OP_LOOP_AUTO_NUMBERING) begin
        next_auto_addr <= my_addr + 7'h01;
      end
      if (take && op == lich_pkg::OP_INTEG_SET && cmd_write) begin
        integ_setting <= pwdata[31:24] == 8'h00 ? 16'h0001 : {8'h00, pwdata[31:24]};
      end
      if (wr_en && paddr == lich_pkg::OFF_COEF_IDX) begin
        coef_idx <= (pwdata[4:0] < 5'(lich_pkg::NUM_COEF)) ? pwdata[4:0] : 5'h00;
      end
      if (wr_en && paddr == lich_pkg::OFF_PPER) begin
        pper <= pwdata[15:0];
      end
      if (wr_en && paddr == lich_pkg::OFF_MY_ADDR) begin
        my_addr <= pwdata[6:0];
      end
      if (wr_en && paddr == lich_pkg::OFF_PCALC) begin
        pcalc <= pwdata;
      end
    end
  end

  // Coefficient store; data staged through COEF_DATA and committed by a coefficient write command
  logic [31:0] stage;
  always_ff @(posedge clk) begin
    if (rst) begin
      stage <= 32'h00000000;
      for (int i = 0; i < lich_pkg::NUM_COEF; i++) begin
        coef[i] <= 32'h00000000;
      end
      coef[lich_pkg::COEF_MULT] <= lich_pkg::ONE_Q24;
      coef[lich_pkg::COEF_TBC] <= lich_pkg::ONE_Q24;
    end else begin
      if (wr_en && paddr == lich_pkg::OFF_COEF_DATA) begin
        stage <= pwdata;
      end
      if (take && op == lich_pkg::OP_COEF_ACCESS && cmd_write) begin
        coef[coef_idx] <= (coef_idx == lich_pkg::COEF_SN)
          ? {8'h00, bcd_of(stage)} : stage;
      end
    end
  end

  // Loop relay and reply ordering
  always_ff @(posedge clk) begin
    if (rst) begin
      relay_valid <= 1'b0;
      relay_cmd <= 32'h00000000;
      relay_pend <= 1'b0;
      pend_cmd <= 32'h00000000;
      reply_valid <= 1'b0;
      reply_data <= 32'h00000000;
    end else begin
      relay_valid <= 1'b0;
      reply_valid <= 1'b0;
      if (relay_pend) begin
        relay_valid <= 1'b1;
        relay_cmd <= pend_cmd;
        relay_pend <= 1'b0;
      end
      if (cmd_wr && (is_global || !is_mine)) begin
        if (echo_first || !take) begin
          relay_valid <= 1'b1;
          relay_cmd <= {pwdata[31:15], next_relay_dest, pwdata[7:0]};
        end else begin
          relay_pend <= 1'b1;
          pend_cmd <= pwdata;
        end
      end
      if (take && !diag_op && op != lich_pkg::OP_WRITE_UNLOCK) begin
        reply_valid <= 1'b1;
        reply_data <= (op == lich_pkg::OP_COEF_ACCESS) ? coef_sel
          : (op == lich_pkg::OP_DATA_DUMP) ? held_pressure
          : {27'h0000000, op};
      end
    end
  end

  // Timebase is foreign: two flops first, edge seen on the third
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_s1 <= 1'b0;
      tb_s2 <= 1'b0;
      tb_s3 <= 1'b0;
    end else begin
      tb_s1 <= counter_timebase;
      tb_s2 <= tb_s1;
      tb_s3 <= tb_s2;
    end
  end
  wire tb_rise = tb_s2 && !tb_s3;

  lich_divider #(.DIV(CT_DIV)) u_ct_div (
    .clk(clk),
    .rst(rst),
    .run(diag == lich_pkg::DG_CT),
    .tick(tb_rise),
    .div_out(ct_out)
  );
  lich_divider #(.DIV(CX_DIV)) u_cx_div (
    .clk(clk),
    .rst(rst),
    .run(diag == lich_pkg::DG_CX),
    .tick(1'b1),
    .div_out(cx_out)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      display_clock <= 1'b0;
    end else begin
      display_clock <= ct_out | cx_out;
    end
  end
endmodule : lich_top

// File: testbench/lich_chk.sv
// Concurrent checks on the command handler ports
`timescale 1ns/1ps
module lich_chk #(
  parameter int CT_DIV = 512,
  parameter int CX_DIV = 480
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] live_pressure,
  input wire logic [31:0] live_period,
  input wire logic [31:0] held_period,
  input wire logic display_clock,
  input wire logic relay_valid,
  input wire logic reply_valid,
  input wire logic [31:0] held_pressure,
  input wire logic line_speed_strobe,
  input wire logic [3:0] line_speed_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire cmd_w = psel && penable && pready && pwrite && (paddr == 8'h00);
  wire [4:0] op = pwdata[4:0];
  wire glb = pwdata[14:8] == lich_pkg::GLOBAL_ADDR;
  wire [3:0] spd = pwdata[27:24];
  wire hold_op = (op >= 5'h09) && (op <= 5'h0C);
  sequence glb_query;
    cmd_w && glb && (op == 5'h0D || op == 5'h0E);
  endsequence
  sequence reply_then_relay;
    reply_valid && !relay_valid ##1 relay_valid;
  endsequence
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h2C |-> pslverr)
    else $error("no slave error");
  glob_echo_a: assert property (cmd_w && glb && hold_op |=> relay_valid && reply_valid)
    else $error("echo not with reply");
  query_order_a: assert property (glb_query |=> reply_then_relay)
    else $error("query order wrong");
  diag_silent_a: assert property (cmd_w && (op == 5'h01 || op == 5'h02) |=> !reply_valid [*2])
    else $error("clock check replied");
  speed_glob_a: assert property (cmd_w && glb && op == 5'h05 |=>
    line_speed_strobe && line_speed_code == $past(spd))
    else $error("line speed not set");
  speed_local_a: assert property (cmd_w && !glb && op == 5'h05 |=> !line_speed_strobe)
    else $error("line speed taken locally");
  hold_capture_a: assert property (cmd_w && glb && op == 5'h09 |=>
    held_pressure == $past(live_pressure) && held_period == $past(live_period))
    else $error("capture moment wrong");
  // Display clock sits two flops behind the command edge
  diag_stop_a: assert property (cmd_w && glb && hold_op |=> ##2 !display_clock [*4])
    else $error("display clock kept running");
endmodule : lich_chk

// File: testbench/lich_far_side.sv
// Far-side model: free-running counter timebase and live measurement words
`timescale 1ns/1ps
module lich_far_side #(
  parameter real TB_HALF_NS = 6.5
) (
  input wire logic clk,
  input wire logic rst,
  output logic counter_timebase,
  output logic [31:0] live_pressure,
  output logic [31:0] live_period
);
  // Oscillator is unrelated to clk, so resampled edges wander by a cycle
  initial begin
    counter_timebase = 1'b0;
    forever #(TB_HALF_NS) counter_timebase = ~counter_timebase;
  end
  // Values change every cycle so a late or early capture shows up
  always_ff @(posedge clk) begin
    if (rst) begin
      live_pressure <= 32'h00001000;
      live_period <= 32'h00000700;
    end else begin
      live_pressure <= live_pressure + 32'h00000101;
      live_period <= live_period + 32'h00000003;
    end
  end
endmodule : lich_far_side

// File: testbench/tb_top.sv
// Self-checking bench for the loop instrument command handler
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [4:0] op;
    logic [6:0] dest;
    logic [4:0] mask;
    logic [4:0] exp;
  } lich_row_type;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, relay_cmd, reply_data, held_pressure, held_period;
  logic [31:0] live_pressure, live_period;
  logic counter_timebase, display_clock, relay_valid, reply_valid, line_speed_strobe;
  logic [3:0] line_speed_code;
  logic [6:0] next_auto_addr;
  logic [4:0] seen;
  int err_count, check_count, n;
  // Seen bits: relay and reply in the first cycle, then the second, then strobe
  lich_row_type rows [14] = '{
    '{5'h09, 7'h63, 5'h1F, 5'h18}, '{5'h0D, 7'h63, 5'h1F, 5'h0C},
    '{5'h0E, 7'h63, 5'h1F, 5'h0C}, '{5'h09, 7'h01, 5'h1F, 5'h08},
    '{5'h09, 7'h05, 5'h1F, 5'h10}, '{5'h01, 7'h01, 5'h1F, 5'h00},
    '{5'h02, 7'h01, 5'h1F, 5'h00}, '{5'h03, 7'h63, 5'h1F, 5'h10},
    '{5'h05, 7'h63, 5'h19, 5'h19}, '{5'h05, 7'h01, 5'h01, 5'h00},
    '{5'h06, 7'h01, 5'h1F, 5'h00}, '{5'h08, 7'h63, 5'h1F, 5'h18},
    '{5'h0F, 7'h63, 5'h1F, 5'h18}, '{5'h07, 7'h63, 5'h18, 5'h18}};
  lich_top #(.CT_DIV(8), .CX_DIV(8)) lich_top_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_timebase(counter_timebase),
    .live_pressure(live_pressure), .live_period(live_period), .display_clock(display_clock),
    .relay_valid(relay_valid), .relay_cmd(relay_cmd), .reply_valid(reply_valid),
    .reply_data(reply_data), .held_pressure(held_pressure), .held_period(held_period),
    .next_auto_addr(next_auto_addr), .line_speed_strobe(line_speed_strobe),
    .line_speed_code(line_speed_code));
  lich_far_side lich_far_side_inst (.clk(clk), .rst(rst), .counter_timebase(counter_timebase),
    .live_pressure(live_pressure), .live_period(live_period));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) err_count++;
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, e);
  endtask : rdc
  task automatic cmd(input logic [4:0] op, input logic [6:0] dst, input logic w);
    apb(1'b1, 8'h00, {8'h05, 7'h00, w, 1'b0, dst, 3'h0, op});
    @(negedge clk);
    seen[4:3] = {relay_valid, reply_valid};
    seen[0] = line_speed_strobe;
    @(negedge clk);
    seen[2:1] = {relay_valid, reply_valid};
  endtask : cmd
  // Cycles between two rising edges of the display clock, bounded wait
  task automatic per(output int p);
    int c;
    logic q;
    p = 0;
    c = 0;
    q = 1'b1;
    repeat (300) begin
      @(posedge clk);
      if (display_clock === 1'b1 && !q) c++;
      if (c == 2) break;
      if (c == 1) p++;
      q = display_clock;
    end
  endtask : per
  initial begin
    #40000;
    err_count++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h10, 32'h000000EE);
    rdc(8'h18, 32'h0000029A);
    rdc(8'h1C, 32'h000F40B0);
    rdc(8'h30, 32'h0);
    chk("pslverr", {31'h0, err_seen}, 32'h1);
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].dest, 1'b0);
      chk("pulses", {27'h0, seen & rows[i].mask}, {27'h0, rows[i].exp});
    end
    chk("auto addr", {25'h0, next_auto_addr}, 32'h2);
    chk("relay cmd", relay_cmd, 32'h05000207);
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h0C, 32'h5);
    cmd(5'h04, 7'h01, 1'b1);
    rdc(8'h0C, 32'h0);
    rdc(8'h04, 32'h00000012);
    cmd(5'h03, 7'h01, 1'b0);
    cmd(5'h04, 7'h01, 1'b1);
    rdc(8'h0C, 32'h5);
    cmd(5'h04, 7'h01, 1'b0);
    chk("reply data", reply_data, 32'h5);
    cmd(5'h03, 7'h63, 1'b0);
    apb(1'b1, 8'h0C, 32'h9);
    cmd(5'h04, 7'h63, 1'b1);
    rdc(8'h0C, 32'h5);
    cmd(5'h03, 7'h01, 1'b0);
    cmd(5'h0D, 7'h01, 1'b0);
    cmd(5'h04, 7'h01, 1'b1);
    rdc(8'h0C, 32'h5);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0C, 32'h130C);
    cmd(5'h03, 7'h01, 1'b0);
    cmd(5'h04, 7'h01, 1'b1);
    rdc(8'h0C, 32'h4876);
    apb(1'b1, 8'h0C, 32'hF4240);
    cmd(5'h03, 7'h01, 1'b0);
    cmd(5'h04, 7'h01, 1'b1);
    rdc(8'h0C, 32'h999999);
    apb(1'b1, 8'h08, 32'h3);
    rdc(8'h0C, 32'h01000000);
    apb(1'b1, 8'h2C, 32'h01000000);
    rdc(8'h28, 32'h01000005);
    apb(1'b1, 8'h14, 32'h64);
    rdc(8'h18, 32'h94C);
    rdc(8'h1C, 32'h367950);
    cmd(5'h03, 7'h01, 1'b0);
    cmd(5'h10, 7'h01, 1'b1);
    rdc(8'h10, 32'h5);
    rdc(8'h18, 32'h32);
    cmd(5'h02, 7'h01, 1'b0);
    per(n);
    chk("cx period", n, 32'd8);
    cmd(5'h01, 7'h01, 1'b0);
    per(n);
    chk("ct period", {31'h0, n >= 25 && n <= 27}, 32'h1);
    cmd(5'h09, 7'h63, 1'b0);
    // Display clock sits two flops behind the command edge
    @(posedge clk);
    n = 0;
    repeat (40) @(posedge clk) n += display_clock;
    chk("stopped", n, 32'h0);
    apb(1'b1, 8'h24, 32'h5);
    rdc(8'h24, 32'h5);
    cmd(5'h0D, 7'h05, 1'b0);
    chk("own addr", {27'h0, seen}, 32'h8);
    summarize();
  end
endmodule : tb_top
bind lich_top lich_chk #(.CT_DIV(CT_DIV), .CX_DIV(CX_DIV)) lich_chk_inst (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .live_pressure(live_pressure),
  .live_period(live_period), .held_period(held_period),
  .display_clock(display_clock), .relay_valid(relay_valid), .reply_valid(reply_valid),
  .held_pressure(held_pressure), .line_speed_strobe(line_speed_strobe),
  .line_speed_code(line_speed_code));
